// ---- ipv_cfg.svh ----
// Register map, field positions, reset values and vector tables
`ifndef IPV_CFG_SVH
`define IPV_CFG_SVH
`define IPV_PMC_OFS 16'h103c
`define IPV_EN_OFS 16'h1040
`define IPV_STAT_OFS 16'h1044
`define IPV_PSEL_RST 4'h6
`define IPV_BOOT_BIT 7
`define IPV_SPEC_BIT 6
`define IPV_MODEA_BIT 5
`define IPV_VISCTL_BIT 4
`define IPV_SCI_EN_LSB 16
`define IPV_SCI_RX 0
`define IPV_SCI_TXE 1
`define IPV_SCI_TXC 2
`define IPV_SCI_IDLE 3
`define IPV_STAT_IDX_LSB 16
`define IPV_STAT_VALID_BIT 24
`define IPV_STAT_RXF_BIT 25
`define IPV_CAP_DLY 2'h2
`define IPV_PSEL_LAST_DIRECT 4'h4
`define IPV_PSEL_IRQ 4'h6
`define IPV_IDX_TOV 4'ha
`define IPV_IDX_IRQ 4'h0
`define IPV_VEC_HI 8'hff
`define IPV_VEC_MTBL {8'hd6, 8'hd8, 8'hda, 8'hdc, 8'hde, 8'he0, 8'he2, \
  8'he4, 8'he6, 8'he8, 8'hea, 8'hec, 8'hee, 8'hf0, 8'hf2}
`define IPV_VEC_NTBL {8'hf6, 8'hf8, 8'hf4, 8'hfa, 8'hfc, 8'hfe}
`define IPV_RESP_OKAY 2'h0
`define IPV_RESP_SLVERR 2'h2
`endif

// ---- ipv_pkg.sv ----
// Shared types for the interrupt priority and vector unit
`default_nettype none
package ipv_pkg;
  typedef struct packed {
    logic awvalid;
    logic [15:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [15:0] araddr;
    logic rready;
  } ipv_axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ipv_axi_rsp_t;
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } ipv_wr_t;
  typedef struct packed {
    logic reset_req;
    logic clkmon_fail;
    logic cop_timeout;
    logic illegal_op;
    logic swi;
  } ipv_nm_t;
  typedef struct packed {
    logic rx_full_set;
    logic overrun;
    logic tx_empty;
    logic tx_done;
    logic idle_line;
    logic status_rd;
    logic data_rd;
  } ipv_sci_t;
  typedef struct packed {
    logic aw_held;
    logic [15:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ipv_slv_st_t;
  typedef struct packed {
    logic [3:0] psel;
    logic boot_rd;
    logic spec_mode;
    logic mode_a;
    logic vis_ctl;
    logic [1:0] cap_cnt;
    logic captured;
    logic pina_s1;
    logic pina_s2;
    logic pinb_s1;
    logic pinb_s2;
    logic irq_s1;
    logic irq_s2;
    logic nmi_s1;
    logic nmi_s2;
    logic [13:1] en;
    logic [3:0] sci_en;
    logic rxf;
    logic rxf_armed;
    logic vec_valid;
    logic vec_mask;
    logic [4:0] vec_idx;
    logic [15:0] vec_addr;
  } ipv_st_t;
endpackage
`default_nettype wire

// ---- ipv_prio_resolve.sv ----
// Fixed-order maskable priority pick with one promoted source
`timescale 1ns/100ps
`default_nettype none
module ipv_prio_resolve #(
  parameter int N = 15
) (
  input wire logic [N-1:0] req,
  input wire logic [3:0] promo,
  output logic hit,
  output logic [3:0] idx
);
  if (N < 2 || N > 16) begin : g_chk
    $error("ipv_prio_resolve: N must be 2 to 16");
  end

  always_comb begin
    hit = |req;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = 4'(i);
      end
    end
    // Promotion only reorders; index (and so vector) stays the source's
    if (int'(promo) < N && req[promo]) begin
      idx = promo;
    end
  end
endmodule
`default_nettype wire

// ---- ipv_axil_slave.sv ----
// AXI4-Lite slave front end producing a register write strobe and read address
`timescale 1ns/100ps
`default_nettype none
`include "ipv_cfg.svh"
module ipv_axil_slave (
  input wire logic clk,
  input wire logic rst,
  input wire ipv_pkg::ipv_axi_req_t req,
  output var ipv_pkg::ipv_axi_rsp_t rsp,
  output var ipv_pkg::ipv_wr_t wr,
  input wire logic wr_hit,
  output logic [15:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_hit
);
  import ipv_pkg::*;
  ipv_slv_st_t q, n;
  logic aw_now, w_now, do_wr, do_rd;

  always_comb begin
    aw_now = q.aw_held | req.awvalid;
    w_now = q.w_held | req.wvalid;
    // Hold a new write until the previous response has been taken
    do_wr = aw_now & w_now & ~q.bvalid;
    do_rd = req.arvalid & ~q.rvalid;
    wr.valid = do_wr;
    wr.addr = q.aw_held ? q.aw_addr : req.awaddr;
    wr.data = q.w_held ? q.w_data : req.wdata;
    wr.strb = q.w_held ? q.w_strb : req.wstrb;
    rd_addr = req.araddr;
    n = q;
    if (do_wr) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = wr_hit ? `IPV_RESP_OKAY : `IPV_RESP_SLVERR;
    end else begin
      if (!q.aw_held && req.awvalid) begin
        n.aw_held = 1'b1;
        n.aw_addr = req.awaddr;
      end
      if (!q.w_held && req.wvalid) begin
        n.w_held = 1'b1;
        n.w_data = req.wdata;
        n.w_strb = req.wstrb;
      end
      if (req.bready) begin
        n.bvalid = 1'b0;
      end
    end
    if (do_rd) begin
      n.rvalid = 1'b1;
      n.rdata = rd_data;
      n.rresp = rd_hit ? `IPV_RESP_OKAY : `IPV_RESP_SLVERR;
    end else if (req.rready) begin
      n.rvalid = 1'b0;
    end
  end

  always_comb begin
    rsp.awready = ~q.aw_held;
    rsp.wready = ~q.w_held;
    rsp.bvalid = q.bvalid;
    rsp.bresp = q.bresp;
    rsp.arready = ~q.rvalid;
    rsp.rvalid = q.rvalid;
    rsp.rdata = q.rdata;
    rsp.rresp = q.rresp;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule
`default_nettype wire

// ---- ipv_top.sv ----
// Interrupt priority, vector selection and mode/priority control register
// Summary of operation
// - Special-mode flag = inverted second mode pin
// - Mode-A latch = first mode pin at release
// - Boot-ROM bit only live in special modes
// - Expanded modes: control bit shows internal reads
// - Other modes: control bit gates E-clock pin
// - Promote field raises one maskable source
// - Promote field writable only with I set
// - Codes 0-4: timer ovf, PA ovf/edge, SPI, SCI
// - Codes 5 and 6 promote external request
// - Codes 7-15: periodic, captures, compares, shared
// - Eighteen-plus vectors serve all sources, some shared
// - Maskable sources only while I clear
// - Trap, software and nonmaskable ignore I
// - Five SCI causes, one vector, four enables (receive-full and overrun share one)
// - Receive-full clears on status then data read
// - SPI, PA edge, PA ovf, timer ovf vectors
// - Timer capture/compare vectors fixed descending
// - Reset loads promote field with external request
// - Promotion keeps other sources' order and all vector addresses
`timescale 1ns/100ps
`default_nettype none
`include "ipv_cfg.svh"
module ipv_top #(
  parameter int NSRC = 15
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire ipv_pkg::ipv_axi_req_t axi_req,
  output var ipv_pkg::ipv_axi_rsp_t axi_rsp,
  input wire logic mode_pin_first,
  input wire logic mode_pin_second,
  input wire logic irq_pin_n,
  input wire logic nonmaskable_request_pin_n,
  input wire logic cond_i_mask,
  input wire logic cond_x_mask,
  input wire ipv_pkg::ipv_nm_t nm_req,
  input wire logic [13:1] periph_flag,
  input wire ipv_pkg::ipv_sci_t sci,
  output logic vec_valid,
  output logic [15:0] vec_addr,
  output logic receive_full_flag,
  output logic special_mode_flag,
  output logic mode_a_latch,
  output logic boot_rom_read_bit,
  output logic read_vis_en,
  output logic eclk_out_en
);
  import ipv_pkg::*;

  if (NSRC != 15) begin : g_chk
    $error("ipv_top: vector table serves exactly 15 maskable sources");
  end

  localparam logic [119:0] MTBL = `IPV_VEC_MTBL;
  localparam logic [47:0] NTBL = `IPV_VEC_NTBL;
  localparam ipv_st_t ST_RST = '{
    psel: `IPV_PSEL_RST,
    irq_s1: 1'b1,
    irq_s2: 1'b1,
    nmi_s1: 1'b1,
    nmi_s2: 1'b1,
    default: '0
  };

  ipv_st_t q, n;
  ipv_wr_t wr;
  logic [15:0] rd_addr;
  logic [31:0] rd_data;
  logic wr_hit, rd_hit;
  logic [NSRC-1:0] m_req, m_eff;
  logic [3:0] promo_idx, m_idx;
  logic m_hit;
  logic [5:0] nm_vec;
  logic nm_any;
  logic [2:0] nm_idx;
  logic sci_any;
  logic pmc_wr, en_wr;
  logic [31:0] wmask;

  function automatic logic reg_hit(input logic [15:0] a);
    return a == `IPV_PMC_OFS || a == `IPV_EN_OFS || a == `IPV_STAT_OFS;
  endfunction

  // Codes map to fixed-order index; reserved code acts as external request
  function automatic logic [3:0] psel_index(input logic [3:0] p);
    if (p <= `IPV_PSEL_LAST_DIRECT) begin
      return `IPV_IDX_TOV + p;
    end else if (p <= `IPV_PSEL_IRQ) begin
      return `IPV_IDX_IRQ;
    end
    return p - `IPV_PSEL_IRQ;
  endfunction

  function automatic logic [2:0] first_set(input logic [5:0] v);
    logic [2:0] k;
    k = '0;
    for (int i = 5; i >= 0; i--) begin
      if (v[i]) begin
        k = 3'(i);
      end
    end
    return k;
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{s[i]}};
    end
    return m;
  endfunction

  ipv_axil_slave u_slave (
    .clk(core_clk),
    .rst(rst),
    .req(axi_req),
    .rsp(axi_rsp),
    .wr(wr),
    .wr_hit(wr_hit),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  ipv_prio_resolve #(
    .N(NSRC)
  ) u_resolve (
    .req(m_eff),
    .promo(promo_idx),
    .hit(m_hit),
    .idx(m_idx)
  );

  always_comb begin
    // One vector pair for all five serial causes
    sci_any = (q.rxf | sci.overrun) & q.sci_en[`IPV_SCI_RX]
      | sci.tx_empty & q.sci_en[`IPV_SCI_TXE]
      | sci.tx_done & q.sci_en[`IPV_SCI_TXC]
      | sci.idle_line & q.sci_en[`IPV_SCI_IDLE];
    m_req = {sci_any, periph_flag & q.en, ~q.irq_s2};
    m_eff = cond_i_mask ? '0 : m_req;
    promo_idx = psel_index(q.psel);
    // Pin request still obeys X; I never blocks these
    nm_vec = {nm_req.swi, nm_req.illegal_op,
      ~q.nmi_s2 & ~cond_x_mask, nm_req.cop_timeout,
      nm_req.clkmon_fail, nm_req.reset_req};
    nm_any = |nm_vec;
    nm_idx = first_set(nm_vec);
    wr_hit = reg_hit(wr.addr);
    rd_hit = reg_hit(rd_addr);
    pmc_wr = wr.valid && wr.addr == `IPV_PMC_OFS && wr.strb[0];
    en_wr = wr.valid && wr.addr == `IPV_EN_OFS;
    wmask = lane_mask(wr.strb);
  end

  always_comb begin
    rd_data = '0;
    if (rd_addr == `IPV_PMC_OFS) begin
      rd_data[7:0] = {q.boot_rd, q.spec_mode, q.mode_a, q.vis_ctl, q.psel};
    end else if (rd_addr == `IPV_EN_OFS) begin
      rd_data[13:1] = q.en;
      rd_data[`IPV_SCI_EN_LSB +: 4] = q.sci_en;
    end else if (rd_addr == `IPV_STAT_OFS) begin
      rd_data[15:0] = q.vec_addr;
      rd_data[`IPV_STAT_IDX_LSB +: 5] = q.vec_idx;
      rd_data[`IPV_STAT_VALID_BIT] = q.vec_valid;
      rd_data[`IPV_STAT_RXF_BIT] = q.rxf;
    end
  end

  always_comb begin
    n = q;
    // Pins are asynchronous: two stages before anything reads them
    n.pina_s1 = mode_pin_first;
    n.pina_s2 = q.pina_s1;
    n.pinb_s1 = mode_pin_second;
    n.pinb_s2 = q.pinb_s1;
    n.irq_s1 = irq_pin_n;
    n.irq_s2 = q.irq_s1;
    n.nmi_s1 = nonmaskable_request_pin_n;
    n.nmi_s2 = q.nmi_s1;
    // Strap capture waits for the synchronisers to fill after release
    if (!q.captured) begin
      n.cap_cnt = q.cap_cnt + 2'h1;
      if (q.cap_cnt == `IPV_CAP_DLY) begin
        n.cap_cnt = q.cap_cnt;
        n.captured = 1'b1;
        n.spec_mode = ~q.pinb_s2;
        n.mode_a = q.pina_s2;
        n.boot_rd = ~q.pinb_s2 & ~q.pina_s2;
        n.vis_ctl = ~q.pinb_s2 & q.pina_s2;
      end
    end
    if (pmc_wr) begin
      n.vis_ctl = wr.data[`IPV_VISCTL_BIT];
      if (q.spec_mode) begin
        n.boot_rd = wr.data[`IPV_BOOT_BIT];
      end
      // Changing order while I is clear could race the CPU fetch
      if (cond_i_mask) begin
        n.psel = wr.data[3:0];
      end
    end
    if (!n.spec_mode) begin
      n.boot_rd = 1'b0;
    end
    if (en_wr) begin
      n.en = (q.en & ~wmask[13:1]) | (wr.data[13:1] & wmask[13:1]);
      n.sci_en = (q.sci_en & ~wmask[`IPV_SCI_EN_LSB +: 4])
        | (wr.data[`IPV_SCI_EN_LSB +: 4] & wmask[`IPV_SCI_EN_LSB +: 4]);
    end
    if (sci.data_rd && q.rxf_armed) begin
      n.rxf = 1'b0;
      n.rxf_armed = 1'b0;
    end else if (sci.status_rd && q.rxf) begin
      n.rxf_armed = 1'b1;
    end
    // A new character in the clearing cycle is kept
    if (sci.rx_full_set) begin
      n.rxf = 1'b1;
    end
    n.vec_valid = nm_any | m_hit;
    if (nm_any) begin
      n.vec_mask = 1'b0;
      n.vec_idx = {2'b10, nm_idx};
      n.vec_addr = {`IPV_VEC_HI, NTBL[{nm_idx, 3'b000} +: 8]};
    end else if (m_hit) begin
      n.vec_mask = 1'b1;
      n.vec_idx = {1'b0, m_idx};
      n.vec_addr = {`IPV_VEC_HI, MTBL[{m_idx, 3'b000} +: 8]};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= ST_RST;
    end else begin
      q <= n;
    end
  end

  assign vec_valid = q.vec_valid;
  assign vec_addr = q.vec_addr;
  assign receive_full_flag = q.rxf;
  assign special_mode_flag = q.spec_mode;
  assign mode_a_latch = q.mode_a;
  assign boot_rom_read_bit = q.boot_rd;
  assign read_vis_en = q.mode_a & q.vis_ctl;
  // Expanded modes always drive E; bit is "not E" otherwise
  assign eclk_out_en = q.mode_a | ~q.vis_ctl;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  chk_spec_capture: assert property (
    $rose(q.captured) |-> q.spec_mode == !$past(q.pinb_s2))
    else $error("special mode flag not the inverted pin");

  chk_modea_capture: assert property (
    $rose(q.captured) |-> q.mode_a == $past(q.pina_s2))
    else $error("mode A latch not the pin level");

  chk_boot_gate: assert property (
    !special_mode_flag |-> !boot_rom_read_bit)
    else $error("boot rom bit set outside special modes");

  chk_vis_expanded: assert property (
    read_vis_en |-> mode_a_latch && q.vis_ctl && eclk_out_en)
    else $error("read visibility outside expanded mode");

  chk_eclk_drive: assert property (
    !mode_a_latch |-> eclk_out_en == !q.vis_ctl)
    else $error("E clock enable does not follow control bit");

  chk_psel_locked: assert property (
    pmc_wr && !cond_i_mask |=> $stable(q.psel))
    else $error("promote field written with I clear");

  chk_psel_taken: assert property (
    pmc_wr && cond_i_mask |=> q.psel == $past(wr.data[3:0]))
    else $error("promote field write lost");

  chk_mask_block: assert property (
    cond_i_mask && !nm_any |=> !vec_valid)
    else $error("maskable vector offered with I set");

  chk_nm_unblocked: assert property (
    nm_any |=> vec_valid && !q.vec_mask && vec_addr >= 16'hfff4)
    else $error("nonmaskable request not presented");

  chk_promote_wins: assert property (
    !cond_i_mask && !nm_any && m_req[promo_idx]
      |=> q.vec_idx == {1'b0, $past(promo_idx)})
    else $error("promoted source not selected");

  chk_rxf_clear: assert property (
    sci.data_rd && q.rxf_armed && !sci.rx_full_set |=> !receive_full_flag)
    else $error("receive full flag not cleared");

  cov_promoted_over_lower: cover property (
    !cond_i_mask && !nm_any && m_req[promo_idx] && m_req[0]
      && promo_idx != 4'h0);

  cov_rxf_sequence: cover property (
    sci.status_rd && q.rxf ##[1:4] sci.data_rd && q.rxf_armed);

  cov_nm_over_masked: cover property (nm_any && m_hit);

  cov_special_boot: cover property ($rose(q.captured) && boot_rom_read_bit);
endmodule
`default_nettype wire

// ---- ipv_cpu_model.sv ----
// Behavioural CPU core: condition mask bits and vector fetch
`timescale 1ns/100ps
`default_nettype none
module ipv_cpu_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic i_want,
  input wire logic x_want,
  input wire logic vec_valid,
  input wire logic [15:0] vec_addr,
  output logic cond_i_mask,
  output logic cond_x_mask,
  output logic [15:0] fetched
);
  import ipv_pkg::*;
  // Both masks set out of reset; X may be cleared but never set again
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cond_i_mask <= 1'h1;
      cond_x_mask <= 1'h1;
      fetched <= 16'h0000;
    end else begin
      cond_i_mask <= i_want;
      cond_x_mask <= cond_x_mask & x_want;
      if (vec_valid) begin
        fetched <= vec_addr;
      end
    end
  end
endmodule
`default_nettype wire

// ---- interrupt_priority_vector_unit_tb.sv ----
// Self-checking bench for the interrupt priority and vector unit
`timescale 1ns/100ps
`default_nettype none
module interrupt_priority_vector_unit_tb;
  import ipv_pkg::*;
  logic core_clk, rst, mode_a, mode_b, irq_n, nmi_n, i_want, x_want;
  logic i_mask, x_mask, vec_valid, rxf, spec, ma_latch, boot_rd, rv_en, ec_en;
  logic [15:0] vec_addr, fetched;
  logic [13:1] periph_flag;
  logic [31:0] rd, exp_vec;
  logic [1:0] resp;
  ipv_axi_req_t req;
  ipv_axi_rsp_t rsp;
  ipv_nm_t nm_req;
  ipv_sci_t sci;
  int err_total, n_checks, cyc;
  // Source index promoted by each code; 0101 falls back to the pin
  logic [3:0] pidx [16] = '{4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'h0, 4'h0,
    4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};

  ipv_top ipv_top_inst (.core_clk(core_clk), .rst(rst), .axi_req(req),
    .axi_rsp(rsp), .mode_pin_first(mode_a), .mode_pin_second(mode_b),
    .irq_pin_n(irq_n), .nonmaskable_request_pin_n(nmi_n),
    .cond_i_mask(i_mask), .cond_x_mask(x_mask), .nm_req(nm_req),
    .periph_flag(periph_flag), .sci(sci), .vec_valid(vec_valid),
    .vec_addr(vec_addr), .receive_full_flag(rxf),
    .special_mode_flag(spec), .mode_a_latch(ma_latch),
    .boot_rom_read_bit(boot_rd), .read_vis_en(rv_en), .eclk_out_en(ec_en));

  ipv_cpu_model ipv_cpu_model_inst (.clk(core_clk), .rst(rst),
    .i_want(i_want), .x_want(x_want), .vec_valid(vec_valid),
    .vec_addr(vec_addr), .cond_i_mask(i_mask), .cond_x_mask(x_mask),
    .fetched(fetched));

  initial begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Extra edge at the end so a following call never re-drives bready
  task automatic axw(input logic [15:0] a, input logic [31:0] d);
    req.awvalid <= 1'h1;
    req.awaddr <= a;
    req.wvalid <= 1'h1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'h1;
    forever begin
      @(posedge core_clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'h0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'h0;
      if (rsp.bvalid) break;
    end
    resp = rsp.bresp;
    req.bready <= 1'h0;
    tick(1);
  endtask

  task automatic axr(input logic [15:0] a);
    req.arvalid <= 1'h1;
    req.araddr <= a;
    req.rready <= 1'h1;
    forever begin
      @(posedge core_clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'h0;
      if (rsp.rvalid) break;
    end
    rd = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'h0;
    tick(1);
  endtask

  task automatic t_boot;
    axr(16'h103c);
    chk({24'h0, rd[7:0]}, 32'hc6);
    chk({27'h0, spec, ma_latch, boot_rd, rv_en, ec_en}, 32'h15);
    axw(16'h103c, 32'h96);
    tick(2);
    chk({30'h0, rv_en, ec_en}, 32'h0);
    i_want <= 1'h0;
    tick(2);
    axw(16'h103c, 32'h90);
    axr(16'h103c);
    chk({24'h0, rd[7:0]}, 32'hd6);
    axr(16'h1050);
    chk({30'h0, resp}, 32'h2);
    chk(rd, 32'h0);
  endtask

  task automatic t_prio;
    i_want <= 1'h1;
    axw(16'h1040, 32'h000f3ffe);
    periph_flag <= 13'h1fff;
    sci.tx_empty <= 1'h1;
    irq_n <= 1'h0;
    for (int c = 0; c < 16; c++) begin
      i_want <= 1'h1;
      tick(2);
      axw(16'h103c, {24'h0, 4'h9, c[3:0]});
      chk({31'h0, vec_valid}, 32'h0);
      i_want <= 1'h0;
      tick(5);
      exp_vec = 32'hfff2 - {pidx[c], 1'h0};
      chk({16'h0, fetched}, exp_vec);
    end
  endtask

  task automatic t_nonmask;
    i_want <= 1'h1;
    nm_req.swi <= 1'h1;
    tick(4);
    chk({16'h0, fetched}, 32'hfff6);
    nm_req.illegal_op <= 1'h1;
    tick(3);
    chk({16'h0, fetched}, 32'hfff8);
    x_want <= 1'h0;
    nmi_n <= 1'h0;
    tick(6);
    chk({16'h0, fetched}, 32'hfff4);
    nm_req <= '0;
    nmi_n <= 1'h1;
    periph_flag <= 13'h0;
    sci <= '0;
    irq_n <= 1'h1;
    i_want <= 1'h0;
    tick(6);
    chk({31'h0, vec_valid}, 32'h0);
  endtask

  task automatic t_rxf;
    sci.rx_full_set <= 1'h1;
    tick(1);
    sci.rx_full_set <= 1'h0;
    sci.data_rd <= 1'h1;
    tick(1);
    sci.data_rd <= 1'h0;
    tick(2);
    chk({31'h0, rxf}, 32'h1);
    sci.status_rd <= 1'h1;
    tick(1);
    sci.status_rd <= 1'h0;
    sci.data_rd <= 1'h1;
    tick(1);
    sci.data_rd <= 1'h0;
    tick(2);
    chk({31'h0, rxf}, 32'h0);
  endtask

  // Second reset in expanded mode: boot bit dead, control bit shows reads
  task automatic t_expanded;
    rst <= 1'h1;
    mode_a <= 1'h1;
    mode_b <= 1'h1;
    i_want <= 1'h1;
    tick(3);
    rst <= 1'h0;
    tick(8);
    axr(16'h103c);
    chk({24'h0, rd[7:0]}, 32'h26);
    axw(16'h103c, 32'h96);
    axr(16'h103c);
    chk({24'h0, rd[7:0]}, 32'h36);
    chk({30'h0, rv_en, ec_en}, 32'h3);
  endtask

  task automatic end_of_test;
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      end_of_test;
    end
  end

  initial begin
    rst = 1'h1;
    req = '0;
    mode_a = 1'h0;
    mode_b = 1'h0;
    irq_n = 1'h1;
    nmi_n = 1'h1;
    i_want = 1'h1;
    x_want = 1'h1;
    nm_req = '0;
    periph_flag = 13'h0;
    sci = '0;
    repeat (12) @(posedge core_clk);
    rst <= 1'h0;
    tick(10);
    t_boot;
    t_prio;
    t_nonmask;
    t_rxf;
    t_expanded;
    end_of_test;
  end
endmodule
`default_nettype wire
